// >>> logic/flash_cmd_pkg.sv
/*
  Shared constants for the serial flash command block: opcodes, address
  fields, status bit positions and timing figures.
  Assumes a single 100 MHz core clock and an SPI link sampled on it.
*/
package flash_cmd_pkg;
  localparam logic [7:0] OP_BUSY_STREAM  = 8'h25;
  localparam logic [7:0] OP_RMW          = 8'h0a;
  localparam logic [7:0] OP_BATTERY_TEST = 8'hef;
  localparam logic [7:0] OP_READ_STATUS  = 8'h65;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] BATTERY_STATUS_ADDR = 8'h06;
  localparam int ADDR_BYTES        = 3;
  localparam int PAGE_MSB          = 19;
  localparam int PAGE_LSB          = 8;
  localparam int PAGE_BYTES        = 256;
  localparam int BATT_RESULT_MSB   = 7;
  localparam int BATT_RESULT_LSB   = 6;
  localparam int BATT_THRESH_MSB   = 5;
  localparam int BATT_THRESH_LSB   = 3;
  localparam int BATT_PARAM_MSB    = 5;
  localparam logic [1:0] BATT_ABOVE = 2'h2;
  localparam logic [1:0] BATT_BELOW = 2'h3;
  localparam logic [7:0] BATT_STATUS_RESET = 8'h00;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int BYTE_TIME_NS      = 100;
  localparam int BYTE_CYCLES       = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BATT_TIME_NS      = 2000;
  localparam int BATT_CYCLES       = (BATT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> logic/pair_buffer.sv
/*
  Two-entry valid/ready buffer for received bytes.
  Assumes both sides share ref_clk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,   // Core clock
  input  wire logic             rst_n,     // Sync reset, active low
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  out_valid, // Word held
  input  wire logic             out_ready, // Drain accepts
  output logic [WIDTH-1:0]      out_data   // Oldest word
);
  logic [WIDTH-1:0] slot [2];
  logic [1:0]       count;
  logic             rd_ptr;
  logic             wr_ptr;
  logic [1:0]       next_count;
  logic             next_rd_ptr;
  logic             next_wr_ptr;
  logic             push;
  logic             pop;

  // Pointer and occupancy update
  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count  = count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count  <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      count  <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];
endmodule
`default_nettype wire

// >>> logic/flash_cmd_engine.sv
/*
  Command interpreter for busy streaming, single-command read-modify-write
  and battery test, with the serial output pin.
  Assumes an SPI host in mode 0 or 3; the link clock is slower than ref_clk
  and reaches this block only through synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_engine
  import flash_cmd_pkg::*;
#(
  parameter int WORK_CYCLES = BATT_CYCLES
) (
  input  wire logic       ref_clk,           // 100 MHz core clock
  input  wire logic       rst_n,             // Sync reset, active low
  input  wire logic       cs_n,              // Chip select pin, active low
  input  wire logic       sck,               // Serial clock pin
  input  wire logic       si,                // Serial data in pin
  output logic            so,                // Serial data out
  output logic            so_oe,             // High while driving so
  input  wire logic       write_enable_latch, // Latch from write-enable logic
  input  wire logic       battery_low,       // Comparator: below threshold
  input  wire logic       cell_fail,         // Array reports a bad byte
  output logic            busy_flag,         // Self-timed work in progress
  output logic            erase_error_flag,  // Erase failure seen
  output logic            program_error_flag, // Program failure seen
  output logic [7:0]      battery_test_status, // Result and parameters
  output logic            mem_we,            // Array byte write strobe
  output logic [19:0]     mem_addr,          // Array byte address
  output logic [7:0]      mem_wdata          // Array byte data
);
  // Elaboration-time refusal of a work time the counter cannot serve
  if (WORK_CYCLES < 1) begin : g_bad_work_cycles
    $error("WORK_CYCLES must be at least 1");
  end

  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01, ST_OPCODE = 6'h02, ST_ADDR  = 6'h04,
    ST_DATA    = 6'h08, ST_STREAM = 6'h10, ST_SHOUT = 6'h20
  } cmd_state_type;
  typedef enum logic [2:0] {
    WK_IDLE = 3'h1, WK_RMW = 3'h2, WK_BATT = 3'h4
  } work_state_type;

  // Two-flop synchronisers for pins
  logic [2:0] cs_sync;
  logic [2:0] sck_sync;
  logic [1:0] si_sync;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
      si_sync  <= 2'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], cs_n};
      sck_sync <= {sck_sync[1:0], sck};
      si_sync  <= {si_sync[0], si};
    end
  end
  logic cs_low, cs_rise, sck_rise, sck_fall;
  assign cs_low   = !cs_sync[1];
  assign cs_rise  = cs_sync[1] && !cs_sync[2];
  assign sck_rise = sck_sync[1] && !sck_sync[2] && cs_low;
  assign sck_fall = !sck_sync[1] && sck_sync[2] && cs_low;

  cmd_state_type    state, next_state;
  work_state_type   work, next_work;
  logic [7:0]  shreg, next_shreg;
  logic [2:0]  bitcnt, next_bitcnt;
  logic [1:0]  addr_cnt, next_addr_cnt;
  logic [23:0] addr, next_addr;
  logic [7:0]  opcode, next_opcode;
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] touched, next_touched;
  logic [7:0]  wptr, next_wptr;
  logic [7:0]  out_byte, next_out_byte;
  logic        pend_rmw, next_pend_rmw;
  logic        pend_batt, next_pend_batt;
  logic [8:0]  scan, next_scan;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic        next_busy, next_ee, next_pe;
  logic [7:0]  next_batt;
  logic        next_so, next_so_oe, next_we;
  logic [19:0] next_mem_addr;
  logic [7:0]  next_mem_wdata;
  logic        byte_done;
  logic        buf_valid, buf_ready, buf_out_valid;
  logic [7:0]  buf_data;
  logic [7:0]  rx_byte;

  assign rx_byte   = {shreg[6:0], si_sync[1]};
  assign byte_done = sck_rise && (bitcnt == 3'h7);

  // Received data bytes pass through here to the page buffer; the drain side always accepts, so none stall
  pair_buffer #(.WIDTH(8)) u_rx_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (rx_byte),
    .out_valid (buf_out_valid),
    .out_ready (1'b1),
    .out_data  (buf_data)
  );
  assign buf_valid = (state == ST_DATA) && byte_done;

  // Page buffer fill, wrapping pointer
  always_ff @(posedge ref_clk) begin
    if (buf_out_valid) begin
      page_buf[wptr] <= buf_data;
    end
  end

  // Command decode and serial shifting
  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_bitcnt    = bitcnt;
    next_addr_cnt  = addr_cnt;
    next_addr      = addr;
    next_opcode    = opcode;
    next_touched   = touched;
    next_wptr      = wptr;
    next_out_byte  = out_byte;
    next_pend_rmw  = 1'b0;
    next_pend_batt = 1'b0;
    next_so        = so;
    next_so_oe     = so_oe;
    if (sck_rise) begin
      next_shreg  = rx_byte;
      next_bitcnt = bitcnt + 3'h1;
    end
    if (buf_out_valid) begin
      next_touched[wptr] = 1'b1;
      next_wptr          = wptr + 8'h1;
    end
    unique case (state)
      ST_STANDBY: begin
        if (cs_low) begin
          next_state   = ST_OPCODE;
          next_bitcnt  = 3'h0;
          next_touched = '0;
        end
      end
      ST_OPCODE: begin
        if (byte_done) begin
          next_opcode = rx_byte;
          if (rx_byte == OP_BUSY_STREAM) begin
            next_state = ST_STREAM;
            next_so_oe = 1'b1;
          end else if (rx_byte == OP_RMW && write_enable_latch && work == WK_IDLE) begin
            next_state    = ST_ADDR;
            next_addr_cnt = 2'h0;
          end else if (rx_byte == OP_READ_STATUS) begin
            next_state    = ST_ADDR;
            next_addr_cnt = 2'(ADDR_BYTES - 1);
          end else if (rx_byte != OP_BATTERY_TEST) begin
            next_state = ST_STREAM; // Unknown or refused opcode: sit quiet until select rises
            next_opcode = 8'h00;
          end
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          next_addr     = {addr[15:0], rx_byte};
          next_addr_cnt = addr_cnt + 2'h1;
          if (addr_cnt == 2'(ADDR_BYTES - 1)) begin
            if (opcode == OP_RMW) begin
              next_state = ST_DATA;
              next_wptr  = rx_byte;
            end else begin
              next_state    = ST_SHOUT;
              next_out_byte = (rx_byte == BATTERY_STATUS_ADDR) ? battery_test_status : 8'h00;
            end
          end
        end
      end
      ST_DATA: begin
      end
      ST_STREAM: begin
        // Input after opcode or dummy byte is ignored
        if (opcode == OP_BUSY_STREAM) begin
          next_so = busy_flag;
        end
      end
      ST_SHOUT: begin
        if (sck_fall) begin
          next_so_oe    = 1'b1;
          next_so       = out_byte[7];
          next_out_byte = {out_byte[6:0], out_byte[7]};
        end
      end
      default: next_state = ST_STANDBY;
    endcase
    if (cs_rise) begin
      next_state = ST_STANDBY;
      next_so_oe = 1'b0;
      next_so    = 1'b0;
      if (bitcnt == 3'h0) begin
        next_pend_rmw  = (state == ST_DATA) && (touched != '0 || buf_out_valid);
        next_pend_batt = (state == ST_OPCODE) && (opcode == OP_BATTERY_TEST);
      end
    end
  end

  // Self-timed work: rewrite touched bytes, or run the battery test
  always_comb begin
    next_work      = work;
    next_scan      = scan;
    next_wait_cnt  = wait_cnt;
    next_busy      = busy_flag;
    next_ee        = erase_error_flag;
    next_pe        = program_error_flag;
    next_batt      = battery_test_status;
    next_we        = 1'b0;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    unique case (work)
      WK_IDLE: begin
        if (pend_rmw) begin
          next_work = WK_RMW;
          next_busy = 1'b1;
          next_scan = 9'h000;
        end else if (pend_batt) begin
          next_work     = WK_BATT;
          next_busy     = 1'b1;
          next_wait_cnt = 32'(WORK_CYCLES);
        end
      end
      WK_RMW: begin
        if (scan == 9'(PAGE_BYTES)) begin
          next_work = WK_IDLE;
          next_busy = 1'b0;
        end else begin
          if (touched[scan[7:0]]) begin
            next_we        = 1'b1;
            next_mem_addr  = {addr[PAGE_MSB:PAGE_LSB], scan[7:0]};
            next_mem_wdata = page_buf[scan[7:0]];
          end
          if (mem_we && cell_fail) begin
            next_ee = 1'b1;
            next_pe = 1'b1;
          end
          next_scan = scan + 9'h001;
        end
      end
      WK_BATT: begin
        if (wait_cnt <= 32'h1) begin
          next_work = WK_IDLE;
          next_busy = 1'b0;
          next_batt[BATT_RESULT_MSB:BATT_RESULT_LSB] =
            battery_low ? BATT_BELOW : BATT_ABOVE;
        end else begin
          next_wait_cnt = wait_cnt - 32'h1;
        end
      end
      default: next_work = WK_IDLE;
    endcase
  end

  // Registers; reset lands in standby
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= ST_STANDBY;
      work     <= WK_IDLE;
      shreg    <= 8'h00;
      bitcnt   <= 3'h0;
      addr_cnt <= 2'h0;
      addr     <= 24'h000000;
      opcode   <= 8'h00;
      touched  <= '0;
      wptr     <= 8'h00;
      out_byte <= 8'h00;
      pend_rmw <= 1'b0;
      pend_batt <= 1'b0;
      scan     <= 9'h000;
      wait_cnt <= 32'h0;
      busy_flag <= 1'b0;
      erase_error_flag <= 1'b0;
      program_error_flag <= 1'b0;
      battery_test_status <= BATT_STATUS_RESET;
      so       <= 1'b0;
      so_oe    <= 1'b0;
      mem_we   <= 1'b0;
      mem_addr <= 20'h00000;
      mem_wdata <= 8'h00;
    end else begin
      state    <= next_state;
      work     <= next_work;
      shreg    <= next_shreg;
      bitcnt   <= next_bitcnt;
      addr_cnt <= next_addr_cnt;
      addr     <= next_addr;
      opcode   <= next_opcode;
      touched  <= next_touched;
      wptr     <= next_wptr;
      out_byte <= next_out_byte;
      pend_rmw <= next_pend_rmw;
      pend_batt <= next_pend_batt;
      scan     <= next_scan;
      wait_cnt <= next_wait_cnt;
      busy_flag <= next_busy;
      erase_error_flag <= next_ee;
      program_error_flag <= next_pe;
      battery_test_status <= next_batt;
      so       <= next_so;
      so_oe    <= next_so_oe;
      mem_we   <= next_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Checks
  property p_stream_follows_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_STREAM && opcode == OP_BUSY_STREAM && !cs_rise) |=> (so == $past(busy_flag));
  endproperty
  a_stream_follows_busy: assert property (p_stream_follows_busy) else $error("stream lags busy");

  property p_cs_rise_tristate;
    @(posedge ref_clk) disable iff (!rst_n) cs_rise |=> (!so_oe && state == ST_STANDBY);
  endproperty
  a_cs_rise_tristate: assert property (p_cs_rise_tristate) else $error("so not released");

  property p_rmw_busy;
    @(posedge ref_clk) disable iff (!rst_n) (work == WK_RMW) |-> busy_flag;
  endproperty
  a_rmw_busy: assert property (p_rmw_busy) else $error("busy low during rewrite");

  property p_pend_starts;
    @(posedge ref_clk) disable iff (!rst_n) (pend_rmw && work == WK_IDLE) |=> (work == WK_RMW && busy_flag);
  endproperty
  a_pend_starts: assert property (p_pend_starts) else $error("rewrite did not start");

  property p_no_write_when_idle;
    @(posedge ref_clk) disable iff (!rst_n) (work == WK_IDLE && !$past(work == WK_RMW)) |-> !mem_we;
  endproperty
  a_no_write_when_idle: assert property (p_no_write_when_idle) else $error("stray write");

  property p_busy_no_rise_stream;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_STREAM && opcode == OP_BUSY_STREAM && !so && !busy_flag && !cs_rise) |=> !so;
  endproperty
  a_busy_no_rise_stream: assert property (p_busy_no_rise_stream) else $error("stream rose");

  property p_wel_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_OPCODE && byte_done && rx_byte == OP_RMW && !write_enable_latch) |=> state != ST_ADDR;
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("rewrite without latch");

  property p_batt_done;
    @(posedge ref_clk) disable iff (!rst_n)
      (work == WK_BATT && wait_cnt <= 32'h1) |=> (!busy_flag && battery_test_status[BATT_RESULT_MSB]);
  endproperty
  a_batt_done: assert property (p_batt_done) else $error("battery result missing");
endmodule
`default_nettype wire

// >>> verif/spi_host_model.sv
/*
  SPI host model for the flash command block: mode 0, 80 ns link clock.
  Assumes the bench calls its tasks and ref_clk runs at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic ref_clk, // Core clock, paces the link
  input  wire logic so,      // Serial out from device
  output logic      cs_n,    // Chip select, active low
  output logic      sck,     // Serial clock
  output logic      si       // Serial in to device
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Clock idles low between frames, so no dummy clocks in mode 0
  task automatic open_frame();
    cs_n <= 1'b0;
    tick(4);
  endtask
  // Four core cycles per phase; MSB leaves first
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      si <= b[i];
      tick(4);
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
    end
    tick(4);
  endtask
  // Sample late in the high phase, well after the falling-edge shift
  task automatic read_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b1;
      tick(4);
      b[i] = so;
      sck <= 1'b0;
      tick(4);
    end
  endtask
  // Released input shows the inverse so a stale level is never trusted
  task automatic close_frame();
    cs_n <= 1'b1;
    si   <= ~si;
    tick(8);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
/*
  Self-checking bench for the flash command block: busy streaming,
  read-modify-write and battery test, against a queue-based model.
  Assumes the design package and the SPI host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_cmd_pkg::*;
  localparam int WORK = 400;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        write_enable_latch = 1'b0;
  logic        battery_low = 1'b0;
  logic        cell_fail = 1'b0;
  logic        busy_flag;
  logic        erase_error_flag;
  logic        program_error_flag;
  logic [7:0]  battery_test_status;
  logic        mem_we;
  logic [19:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [31:0] seed = 32'h7cb25dfa;
  logic [27:0] wr_q[$];
  logic [27:0] exp_q[$];
  int          miscompares = 0;
  int          n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  flash_cmd_engine #(.WORK_CYCLES(WORK)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe(so_oe), .write_enable_latch(write_enable_latch), .battery_low(battery_low),
    .cell_fail(cell_fail), .busy_flag(busy_flag), .erase_error_flag(erase_error_flag),
    .program_error_flag(program_error_flag), .battery_test_status(battery_test_status),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
  );
  spi_host_model host_u (.ref_clk(ref_clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));

  // Every array write the design makes, for order-free comparison
  always @(posedge ref_clk) begin
    if (mem_we === 1'b1) begin
      wr_q.push_back({mem_addr, mem_wdata});
    end
  end

  function automatic logic [7:0] rnd_byte();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait on busy (which 0) or the serial output (which 1)
  task automatic wait_level(input int which, input logic lvl, input int lim);
    int k = 0;
    while (((which == 1) ? so : busy_flag) !== lvl && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= lim) begin
      miscompares++;
      finish_test();
    end
  endtask

  // One read-modify-write frame; extra bits leave it off a byte boundary
  task automatic do_rmw(input logic [23:0] a, input int n, input int extra, input bit ok);
    logic [7:0] d;
    wr_q.delete();
    exp_q.delete();
    host_u.open_frame();
    host_u.send_bits(OP_RMW, 8);
    for (int i = 2; i >= 0; i--) host_u.send_bits(a[i*8+:8], 8);
    for (int i = 0; i < n; i++) begin
      d = rnd_byte();
      host_u.send_bits(d, 8);
      if (ok) exp_q.push_back({a[19:8], 8'(a[7:0] + i), d});
    end
    if (extra > 0) host_u.send_bits(8'h5a, extra);
    host_u.close_frame();
    if (ok) begin
      wait_level(0, 1'b1, 50);
      wait_level(0, 1'b0, 2000);
    end
    host_u.tick(300);
    exp_q.sort();
    wr_q.sort();
    check("write_count", wr_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < wr_q.size()) check("write", wr_q[i], exp_q[i]);
  endtask

  // Battery test, busy streamed to its fall, then result read back
  task automatic battery(input logic low);
    logic [7:0] r;
    battery_low <= low;
    host_u.open_frame();
    host_u.send_bits(OP_BATTERY_TEST, 8);
    host_u.close_frame();
    check("busy_start", busy_flag, 1'b1);
    host_u.open_frame();
    host_u.send_bits(OP_BUSY_STREAM, 8);
    host_u.send_bits(rnd_byte(), 8);
    check("stream_oe", so_oe, 1'b1);
    check("stream_busy", so, 1'b1);
    wait_level(1, 1'b0, 1000);
    check("busy_done", busy_flag, 1'b0);
    host_u.close_frame();
    check("release_oe", so_oe, 1'b0);
    host_u.open_frame();
    host_u.send_bits(OP_READ_STATUS, 8);
    host_u.send_bits(BATTERY_STATUS_ADDR, 8);
    host_u.read_byte(r);
    host_u.close_frame();
    check("status_read", r, {(low ? BATT_BELOW : BATT_ABOVE), 6'h00});
    check("status_port", battery_test_status, {(low ? BATT_BELOW : BATT_ABOVE), 6'h00});
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    host_u.tick(4);
    check("reset_busy", busy_flag, 1'b0);
    check("reset_oe", so_oe, 1'b0);
    check("reset_status", battery_test_status, BATT_STATUS_RESET);
    // Idle stream stays low; off-boundary end aborts it
    host_u.open_frame();
    host_u.send_bits(OP_BUSY_STREAM, 8);
    host_u.tick(20);
    check("idle_stream", so, 1'b0);
    host_u.send_bits(8'ha5, 3);
    host_u.close_frame();
    check("abort_oe", so_oe, 1'b0);
    battery(1'b1);
    battery(1'b0);
    write_enable_latch <= 1'b1;
    do_rmw({rnd_byte(), rnd_byte(), 8'h80}, 256, 0, 1'b1);
    do_rmw({rnd_byte(), rnd_byte(), 8'hff}, 1, 0, 1'b1);
    do_rmw({rnd_byte(), rnd_byte(), 8'h10}, 2, 3, 1'b0);
    check("no_error", {erase_error_flag, program_error_flag}, 2'b00);
    write_enable_latch <= 1'b0;
    do_rmw({rnd_byte(), rnd_byte(), rnd_byte()}, 3, 0, 1'b0);
    write_enable_latch <= 1'b1;
    cell_fail <= 1'b1;
    do_rmw({rnd_byte(), rnd_byte(), 8'h00}, 1, 0, 1'b1);
    check("error_flags", {erase_error_flag, program_error_flag}, 2'b11);
    finish_test();
  end
endmodule
`default_nettype wire
